// ===== coc_channel_ctrl.sv
/*
 * Channel output control register bank: switch word, two drive source banks,
 * pairing register, and the per-channel drive decision built from them.
 * Assumes writes arrive from an SPI frame decoder on sys_clk, one cycle pulse,
 * and that parallel input pins and fault flags are asynchronous.
 */
// How it works
// [R1] Switch word bits 0..9 turn channels 1..10 off when clear, on when set.
// [R2] Switch word resets to C00 hex, all channels off.
// [R3] Switch word top two bits always read one; host writes ones there.
// [R4] Source field upper bit clear: channel follows its switch word bit only.
// [R5] Source field 10: channel follows its own parallel input pin.
// [R6] Source field 11: channel on only when switch bit and pin both one.
// [R7] Bank A holds sources of channels 1..6, resets to AAA hex.
// [R8] Bank B holds sources of channels 7..10 low byte, upper zero, resets 0AA.
// [R9] Set pair bit drives both channels from the lower channel's source.
// [R10] Pair bits at 0..2 and 4..7; bit 3, top nibble zero; reset 000.
// [R11] Clear pair bit leaves both channels independent.
// [R12] Host pairs only within groups 1-4, 5-6, 7-10.
// [R13] Fault on one paired channel sets only that channel's diagnosis bit.
// [R14] Host ORs the paired channels' diagnosis bits itself.
// [R15] Switch word acts on a channel while its source upper bit is clear, and in source field 11.
// [R16] All four registers are written through decoded SPI command frames.
`timescale 1ns/1ps

`include "coc_regs.svh"

module coc_channel_ctrl
    import coc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire coc_wreq_t  wreq,
    input  wire coc_chan_t  parallel_input_pin,
    input  wire coc_chan_t  fault_in,
    output logic            [11:0] channel_switch_data,
    output logic            [11:0] drive_source_bank_a,
    output logic            [11:0] drive_source_bank_b,
    output logic            [11:0] channel_pairing,
    output coc_chan_t       output_channel,
    output coc_chan_t       diag_bit
);

    // ======================================================================
    // Registers
    // ======================================================================
    logic [11:0] data_ff;
    logic [11:0] bank_a_ff;
    logic [11:0] bank_b_ff;
    logic [11:0] pair_ff;
    coc_chan_t   pin_s1_ff;
    coc_chan_t   pin_s2_ff;
    coc_chan_t   flt_s1_ff;
    coc_chan_t   flt_s2_ff;
    coc_chan_t   chan_ff;
    coc_chan_t   diag_ff;
    coc_chan_t   nxt_chan;

    // Drive decision of one channel from its two-bit source field
    function automatic logic chan_decide(input logic [1:0] src,
                                         input logic       on_bit,
                                         input logic       pin);
        if (!src[`COC_SRC_UPPER])
            return on_bit;                                 // R4 R15
        else if (!src[0])
            return pin;                                    // R5
        else
            return on_bit & pin;                           // R6
    endfunction

    // Two-bit source field of channel index k across both banks
    function automatic logic [1:0] src_of(input int k,
                                          input logic [11:0] a,
                                          input logic [11:0] b);
        if (k < `COC_BANK_A_CHN)
            return a[2*k +: 2];                            // R7
        else
            return b[2*(k-`COC_BANK_A_CHN) +: 2];          // R8
    endfunction

    // ======================================================================
    // Register writes from command frames
    // ======================================================================
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_ff   <= `COC_DATA_RST;                    // R2
            bank_a_ff <= `COC_BANK_A_RST;                  // R7
            bank_b_ff <= `COC_BANK_B_RST;                  // R8
            pair_ff   <= `COC_PAIR_RST;                    // R10
        end else if (wreq.wr) begin                        // R16
            case (wreq.sel)
                COC_SEL_DATA: begin
                    // Top bits forced so a careless host write cannot clear them
                    data_ff <= (wreq.data & `COC_DATA_MASK) | `COC_DATA_ONES;  // R1 R3
                end
                COC_SEL_BANK_A: begin
                    bank_a_ff <= wreq.data;                // R7
                end
                COC_SEL_BANK_B: begin
                    bank_b_ff <= wreq.data & `COC_BANK_B_MASK;                 // R8
                end
                COC_SEL_PAIR: begin
                    pair_ff <= wreq.data & `COC_PAIR_MASK;                     // R10
                end
                default: begin
                    data_ff <= data_ff;
                end
            endcase
        end
    end

    // ======================================================================
    // Pin and fault synchronisers
    // ======================================================================
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= parallel_input_pin;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flt_s1_ff <= '0;
            flt_s2_ff <= '0;
        end else begin
            flt_s1_ff <= fault_in;
            flt_s2_ff <= flt_s1_ff;
        end
    end

    // ======================================================================
    // Channel drive with pairing
    // ======================================================================
    // Link k ties channel k to channel k-1; group borders have no link
    logic [`COC_CHN-1:0] link;
    assign link = {pair_ff[7], pair_ff[6], pair_ff[5], 1'b0, pair_ff[4],
                   1'b0, pair_ff[2], pair_ff[1], pair_ff[0], 1'b0};  // R10 R12

    always_comb begin
        nxt_chan = '0;
        for (int k = 0; k < `COC_CHN; k++) begin
            // Chained links pass the lowest channel's decision up the chain
            if (link[k])
                nxt_chan[k] = nxt_chan[(k == 0) ? 0 : k - 1];  // R9
            else
                nxt_chan[k] = chan_decide(src_of(k, bank_a_ff, bank_b_ff),
                                          data_ff[k], pin_s2_ff[k]);  // R1 R11
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chan_ff <= '0;
        end else begin
            chan_ff <= nxt_chan;
        end
    end

    // Diagnosis stays per channel even when paired; the host merges them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            diag_ff <= '0;
        end else begin
            diag_ff <= flt_s2_ff;                          // R13 R14
        end
    end

    assign channel_switch_data = data_ff;
    assign drive_source_bank_a = bank_a_ff;
    assign drive_source_bank_b = bank_b_ff;
    assign channel_pairing     = pair_ff;
    assign output_channel      = chan_ff;
    assign diag_bit            = diag_ff;

    // ======================================================================
    // Assertions
    // ======================================================================
    property p_data_top;
        @(posedge sys_clk) disable iff (!rstn)
        data_ff[11:10] == 2'h3;
    endproperty
    a_data_top: assert property (p_data_top) else $error("switch word top bits not one"); // R3

    property p_data_wr;
        @(posedge sys_clk) disable iff (!rstn)
        (wreq.wr && wreq.sel == COC_SEL_DATA) |=>
            data_ff == {2'h3, $past(wreq.data[9:0])};
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("switch word write wrong"); // R1

    property p_bank_a_wr;
        @(posedge sys_clk) disable iff (!rstn)
        (wreq.wr && wreq.sel == COC_SEL_BANK_A) |=> bank_a_ff == $past(wreq.data);
    endproperty
    a_bank_a_wr: assert property (p_bank_a_wr) else $error("bank A write wrong"); // R7

    property p_bank_b_top;
        @(posedge sys_clk) disable iff (!rstn)
        bank_b_ff[11:8] == 4'h0;
    endproperty
    a_bank_b_top: assert property (p_bank_b_top) else $error("bank B upper bits set"); // R8

    property p_pair_zero;
        @(posedge sys_clk) disable iff (!rstn)
        pair_ff[3] == 1'b0 && pair_ff[11:8] == 4'h0;
    endproperty
    a_pair_zero: assert property (p_pair_zero) else $error("pair reserved bits set"); // R10

    property p_serial;
        @(posedge sys_clk) disable iff (!rstn)
        !bank_a_ff[1] |=> output_channel[0] == $past(data_ff[0]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial mode channel 1 wrong"); // R4

    property p_input;
        @(posedge sys_clk) disable iff (!rstn)
        bank_a_ff[1:0] == 2'h2 |=> output_channel[0] == $past(pin_s2_ff[0]);
    endproperty
    a_input: assert property (p_input) else $error("input mode channel 1 wrong"); // R5

    property p_and;
        @(posedge sys_clk) disable iff (!rstn)
        bank_a_ff[1:0] == 2'h3 |=>
            output_channel[0] == ($past(pin_s2_ff[0]) & $past(data_ff[0]));
    endproperty
    a_and: assert property (p_and) else $error("and mode channel 1 wrong"); // R6

    property p_pair12;
        @(posedge sys_clk) disable iff (!rstn)
        pair_ff[0] |=> output_channel[1] == output_channel[0];
    endproperty
    a_pair12: assert property (p_pair12) else $error("pair 1-2 not in step"); // R9

    property p_direct2;
        @(posedge sys_clk) disable iff (!rstn)
        (!pair_ff[0] && !bank_a_ff[3]) |=> output_channel[1] == $past(data_ff[1]);
    endproperty
    a_direct2: assert property (p_direct2) else $error("channel 2 not independent"); // R11

    property p_diag;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 diag_bit == $past(flt_s2_ff);
    endproperty
    a_diag: assert property (p_diag) else $error("diagnosis bit mismatch"); // R13

    c_pair_on: cover property (@(posedge sys_clk) disable iff (!rstn)
        pair_ff[0] ##1 output_channel[1:0] == 2'h3);
    c_and_mode: cover property (@(posedge sys_clk) disable iff (!rstn)
        bank_a_ff[1:0] == 2'h3 ##1 output_channel[0]);
    c_serial_on: cover property (@(posedge sys_clk) disable iff (!rstn)
        !bank_a_ff[1] && data_ff[0] ##1 output_channel[0]);
    c_diag_one: cover property (@(posedge sys_clk) disable iff (!rstn)
        pair_ff[0] && diag_bit[0] && !diag_bit[1]);

endmodule

// ===== coc_host_model.sv
/*
 * Host side model: writes the four registers one frame at a time and
 * drives the parallel input pins.
 * Assumes a sys_clk shared with the channel output control block.
 */
`timescale 1ns/1ps

module coc_host_model
    import coc_pkg::*;
(
    input  wire logic sys_clk,
    output coc_wreq_t wreq,
    output coc_chan_t parallel_input_pin
);
    initial begin
        wreq = '0;
        parallel_input_pin = '0;
    end

    // ====================
    // Frame writes
    // ====================
    // Raw skips the host's own masking, to reach the forced bits
    task automatic put(input coc_sel_t sel, input logic [11:0] d, input logic raw);
        logic [11:0] v;
        v = d;
        if (!raw && sel == COC_SEL_DATA) v = d | 12'hc00;
        if (!raw && sel == COC_SEL_PAIR) v = d & 12'h0f7;
        @(negedge sys_clk);
        wreq <= '{wr: 1'b1, sel: sel, data: v};
        @(negedge sys_clk);
        wreq <= '{wr: 1'b0, sel: coc_sel_t'(~sel), data: ~v};
    endtask

    task automatic set_pins(input coc_chan_t p);
        @(negedge sys_clk);
        parallel_input_pin <= p;
    endtask

    // Pair fault judged on both channels together
    function automatic logic pair_fault(input coc_chan_t diag, input int lo);
        return diag[lo] | diag[lo+1];
    endfunction
endmodule

// ===== coc_pkg.sv
/*
 * Types shared by the channel output control block.
 * Assumes coc_regs.svh sits in the include path.
 */
`include "coc_regs.svh"

package coc_pkg;

    // ======================================================================
    // Register select from the SPI frame decoder
    // ======================================================================
    typedef enum logic [1:0] {
        COC_SEL_DATA   = 2'h0,
        COC_SEL_BANK_A = 2'h1,
        COC_SEL_BANK_B = 2'h2,
        COC_SEL_PAIR   = 2'h3
    } coc_sel_t;

    // ======================================================================
    // One register write taken from a decoded command frame
    // ======================================================================
    typedef struct packed {
        logic       wr;
        coc_sel_t   sel;
        logic [11:0] data;
    } coc_wreq_t;

    typedef logic [`COC_CHN-1:0] coc_chan_t;

endpackage

// ===== coc_regs.svh
/*
 * Reset values, field masks and field positions of the channel output control registers.
 * Assumes it is included by the package users of the channel output control block.
 */
`ifndef COC_REGS_SVH
`define COC_REGS_SVH

// ==========================================================================
// Reset values
// ==========================================================================
`define COC_DATA_RST    12'hc00
`define COC_BANK_A_RST  12'haaa
`define COC_BANK_B_RST  12'h0aa
`define COC_PAIR_RST    12'h000

// ==========================================================================
// Field masks and positions
// ==========================================================================
`define COC_DATA_ONES   12'hc00
`define COC_DATA_MASK   12'h3ff
`define COC_BANK_B_MASK 12'h0ff
`define COC_PAIR_MASK   12'h0f7
`define COC_BANK_A_CHN  6
`define COC_CHN         10
`define COC_SRC_UPPER   1
`define COC_CH1         0
`define COC_CH2         1

`endif

// ===== tb.sv
/*
 * Self-checking bench of the channel output control block.
 * Assumes coc_pkg and the host model are compiled before it.
 */
`timescale 1ns/1ps

module tb;
    import coc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    coc_wreq_t   wreq;
    coc_chan_t   pin;
    coc_chan_t   fault_in = '0;
    coc_chan_t   och;
    coc_chan_t   diag;
    logic [11:0] r_d;
    logic [11:0] r_a;
    logic [11:0] r_b;
    logic [11:0] r_p;
    logic [31:0] seed = 32'h55b0_2421;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #4 sys_clk = ~sys_clk;

    coc_host_model u_host (.sys_clk(sys_clk), .wreq(wreq), .parallel_input_pin(pin));
    coc_channel_ctrl u_dut (.sys_clk(sys_clk), .rstn(rstn), .wreq(wreq),
        .parallel_input_pin(pin), .fault_in(fault_in), .channel_switch_data(r_d),
        .drive_source_bank_a(r_a), .drive_source_bank_b(r_b), .channel_pairing(r_p),
        .output_channel(och), .diag_bit(diag));

    // ====================
    // Expectation and compare
    // ====================
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic coc_chan_t exp_out(input logic [11:0] d, a, b, p, input coc_chan_t in);
        logic [1:0] s;
        logic [9:0] link;
        coc_chan_t  o;
        link = {p[7:5], 1'b0, p[4], 1'b0, p[2:0], 1'b0};
        for (int i = 0; i < 10; i++) begin
            s = (i < 6) ? a[2*i+:2] : b[2*i-12+:2];
            o[i] = s[1] ? (in[i] & (d[i] | ~s[0])) : d[i];
            if (link[i]) o[i] = o[i-1];
        end
        return o;
    endfunction

    task automatic chk12(input string n, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk10(input string n, input coc_chan_t e, input coc_chan_t g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic regs(input logic [11:0] d, a, b, p);
        chk12("switch", d, r_d);
        chk12("bank_a", a, r_a);
        chk12("bank_b", b, r_b);
        chk12("pairing", p, r_p);
    endtask

    task automatic apply(input logic [11:0] d, a, b, p, input coc_chan_t in, input logic raw);
        coc_chan_t fx;
        fx = in ^ d[9:0];
        u_host.put(COC_SEL_DATA, d, raw);
        u_host.put(COC_SEL_BANK_A, a, raw);
        u_host.put(COC_SEL_BANK_B, b, raw);
        u_host.put(COC_SEL_PAIR, p, raw);
        u_host.set_pins(in);
        fault_in <= fx;
        repeat (4) @(negedge sys_clk);
        regs(d | 12'hc00, a, b & 12'h0ff, p & 12'h0f7);
        chk10("channels", exp_out(d, a, b & 12'h0ff, p & 12'h0f7, in), och);
        chk10("diag", fx, diag);
        chk10("pair_fault", coc_chan_t'(fx[0] | fx[1]), coc_chan_t'(u_host.pair_fault(diag, 0)));
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ====================
    // Sequence
    // ====================
    initial begin
        repeat (4) @(negedge sys_clk);
        rstn <= 1'b1;
        regs(12'hc00, 12'haaa, 12'h0aa, 12'h000);
        chk10("channels", '0, och);
        apply(12'h3ff, 12'hfff, 12'hfff, 12'hfff, 10'h2b6, 1'b1);
        for (int m = 0; m < 4; m++) begin
            apply(12'h2a5, {6{m[1:0]}}, {4'h0, {4{m[1:0]}}}, 12'h000, 10'h34c, 1'b0);
        end
        apply(12'h001, 12'h000, 12'h000, 12'h0f7, 10'h000, 1'b0);
        for (int i = 0; i < 40; i++) begin
            apply(12'(rnd()), 12'(rnd()), 12'(rnd()), 12'(rnd()), 10'(rnd()), i < 4);
        end
        rstn <= 1'b0;
        repeat (2) @(negedge sys_clk);
        regs(12'hc00, 12'haaa, 12'h0aa, 12'h000);
        chk10("channels", '0, och);
        chk10("diag", '0, diag);
        rstn <= 1'b1;
        apply(12'h3ff, 12'h000, 12'h000, 12'h000, 10'h000, 1'b0);
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end
endmodule
